// >>> design/stl_defs.svh
/*
 * register offsets, field positions, reset values and constants of the
 * sequence-table loader; assumes inclusion by the loader design file and the bench.
 */
`ifndef STL_DEFS_SVH
`define STL_DEFS_SVH

// register byte offsets
`define STL_CTRL       8'h00
`define STL_TAB_SEL    8'h04
`define STL_STREAM     8'h08
`define STL_DEF_STEP   8'h0c
`define STL_DEF_SEG    8'h10
`define STL_DEF_LOOPS  8'h14
`define STL_DEF_GO     8'h18
`define STL_TRIGGER    8'h1c
`define STL_DELETE     8'h20
`define STL_STATUS     8'h24
`define STL_STEP       8'h28
`define STL_LENGTH     8'h2c
`define STL_SEGMENT    8'h30

// control, stream and delete fields
`define STL_CTRL_RUN   0
`define STL_CTRL_ADV   1
`define STL_CTRL_JSRC  3
`define STL_CTRL_CH    8
`define STL_STREAM_EOI 8
`define STL_DEL_ALL    31

// reset values
`define STL_CTRL_RST   32'h0000_0000
`define STL_TAB_RST    10'h000

// stream header characters, entry layout and define step limit
`define STL_HASH       8'h23
`define STL_ZERO       8'h30
`define STL_ENTRY_BYTES 3
`define STL_SEG_LSB    32
`define STL_JMP_LSB    48
`define STL_DEF_MAX    16000

`endif

// >>> design/stl_pkg.sv
/*
 * types of the sequence-table loader; assumes nothing outside.
 */
package stl_pkg;
	// advance modes as held in the control register
	typedef enum logic [1:0] {STL_AUTO, STL_ONCE, STL_STEPPED} stl_adv_type;
	// header parser states
	typedef enum logic [1:0] {L_IDLE, L_NDIG, L_COUNT, L_DATA} stl_load_type;
	// step sequencer states
	typedef enum logic [2:0] {Q_IDLE, Q_FETCH, Q_LOAD, Q_PLAY, Q_HOLD, Q_DONE} stl_seq_type;
endpackage : stl_pkg

// >>> design/stl_sequence_table_loader.sv
/*
 * sequence-table loader and step controller with an AXI4-Lite slave.
 * assumes a playback engine on aclk that pulses seg_end at each segment
 * end, and an asynchronous event pin.
 */
// What this block does
// RQ1 - header is hash, digit count, byte count digits
// RQ2 - host sends byte count multiple of eight
// RQ3 - steps assembled as 64-bit entries from bytes
// RQ4 - only EOI ends a block; CR/LF are data
// RQ5 - each channel owns its buffer; selected one written
// RQ6 - host sends 3 to 32768 steps
// RQ7 - no content checks, no error reported
// RQ8 - steps numbered in arrival order from one
// RQ9 - host defines steps ascending, 1 to 16000
// RQ10 - each step holds a segment number
// RQ11 - each step holds a loop count
// RQ12 - jump flag one holds step until advance
// RQ13 - single defines set table length automatically
// RQ14 - define while running restarts the sequence
// RQ15 - 1000 tables per channel, individually deletable
// RQ16 - host rewrites deleted slot no longer
// RQ17 - delete-all clears every table of channel
// RQ18 - bus source advances on trigger write
// RQ19 - event source advances on event input
// RQ20 - automatic mode runs until a jump step
// RQ21 - stepped mode needs advance for every step
// RQ22 - advance mode reads back as its name code
// RQ23 - loop count above one repeats the step
// RQ24 - stepped mode ignores jump flags
// RQ25 - loops low, segment 47:32, jump 63:48
// RQ26 - digit count one to nine, then digits
`timescale 1ns/1ps
`default_nettype none
`include "stl_defs.svh"

module stl_sequence_table_loader
	import stl_pkg::*;
#(
	parameter int NCH   = 2,
	parameter int NTAB  = 1000,
	parameter int DEPTH = 32768
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address and data
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// playback side
	input  wire logic        event_in,
	input  wire logic        seg_end,
	output logic [15:0]      seg_out,
	output logic             seq_active,
	output logic             seq_hold
);
	localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;
	localparam int AW = $clog2(NCH * DEPTH);
	localparam int SW = $clog2(DEPTH) + 1;
	localparam int TW = $clog2(NCH * NTAB);
	localparam logic [SW-1:0] DEF_MAX = SW'(`STL_DEF_MAX);
	localparam logic [SW-1:0] DEP     = SW'(DEPTH);

	// bus slave state
	logic        aw_held;
	logic        w_held;
	logic [7:0]  wa;
	logic [31:0] wd;
	logic        wr_fire;
	logic        wr_ok;
	// software registers
	logic [31:0] ctrl;
	logic [9:0]  tab_sel;
	logic [SW-1:0] def_step;
	logic [15:0] def_seg;
	logic [31:0] def_loops;
	// table bookkeeping
	logic [AW-1:0] tbl_base [NCH*NTAB];
	logic [SW-1:0] tbl_size [NCH*NTAB];
	logic [SW-1:0] tbl_len  [NCH*NTAB];
	logic [NCH*NTAB-1:0] tbl_used;
	logic [SW-1:0] free_off [NCH];
	logic          full;
	// entry memory, one region of DEPTH entries per channel
	logic [63:0] mem [NCH*DEPTH];
	logic [63:0] rd_data;

	wire logic [CW-1:0] ch  = ctrl[`STL_CTRL_CH +: CW];
	wire logic [TW-1:0] cur = TW'(ch * NTAB) + TW'(tab_sel);
	wire logic [AW-1:0] ch_base = AW'(ch * DEPTH);
	wire logic [SW-1:0] cur_free = free_off[ch];

	// write strobes
	assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
	wire logic st_we   = wr_fire & (wa == `STL_STREAM) & s_axi_wstrb[0];
	wire logic def_we  = wr_fire & (wa == `STL_DEF_GO);
	wire logic trig_we = wr_fire & (wa == `STL_TRIGGER);
	wire logic del_we  = wr_fire & (wa == `STL_DELETE);
	wire logic [7:0] st_byte = wd[7:0];
	wire logic       st_eoi  = wd[`STL_STREAM_EOI];

	// aw and w taken in either order; response once both are held
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
	always_comb begin
		unique case (wa)
			`STL_CTRL, `STL_TAB_SEL, `STL_STREAM, `STL_DEF_STEP, `STL_DEF_SEG,
			`STL_DEF_LOOPS, `STL_DEF_GO, `STL_TRIGGER, `STL_DELETE: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// write channel handshake and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			wa           <= 8'h00;
			wd           <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				wa      <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				wd     <= s_axi_wdata;
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// software registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl      <= `STL_CTRL_RST;
			tab_sel   <= `STL_TAB_RST;
			def_step  <= '0;
			def_seg   <= 16'h0000;
			def_loops <= 32'h0000_0001;
		end else if (wr_fire) begin
			unique case (wa)
				`STL_CTRL:      ctrl      <= wd;
				`STL_TAB_SEL:   tab_sel   <= wd[9:0];
				`STL_DEF_STEP:  def_step  <= wd[SW-1:0];
				`STL_DEF_SEG:   def_seg   <= wd[15:0];
				`STL_DEF_LOOPS: def_loops <= wd;
				default: ;
			endcase
		end
	end

	// header parser and byte assembly
	stl_load_type  ld_state;
	logic [3:0]    ld_ndig;
	logic [31:0]   ld_count;
	logic [31:0]   ld_left;
	logic [2:0]    ld_pos;
	logic [55:0]   ld_entry;
	logic [SW-1:0] ld_steps;
	logic [SW-1:0] ld_cap;
	logic [AW-1:0] ld_base;
	logic [TW-1:0] ld_idx;
	logic          ld_ok;
	wire logic [31:0] next_count = ld_count * 32'd10 + 32'(st_byte[3:0]);
	wire logic [SW-1:0] need = next_count[`STL_ENTRY_BYTES +: SW];
	wire logic ld_alloc = st_we & (ld_state == L_COUNT) & (ld_ndig == 4'h1) & ~st_eoi;
	wire logic ld_fits  = (DEP - cur_free) >= need;
	wire logic ld_done  = st_we & (ld_state == L_DATA) & st_eoi;
	wire logic ld_wr    = st_we & (ld_state == L_DATA) & (ld_left != 32'h0)
	                      & (ld_pos == 3'h7) & ld_ok & (ld_steps < ld_cap);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ld_state <= L_IDLE;
			ld_ndig  <= 4'h0;
			ld_count <= 32'h0;
			ld_left  <= 32'h0;
			ld_pos   <= 3'h0;
			ld_entry <= '0;
			ld_steps <= '0;
			ld_cap   <= '0;
			ld_base  <= '0;
			ld_idx   <= '0;
			ld_ok    <= 1'b0;
		end else if (st_we) begin
			unique case (ld_state)
				L_IDLE: if (st_byte == `STL_HASH && !st_eoi) ld_state <= L_NDIG; // see RQ1
				L_NDIG: begin
					// digit count must be 1..9 or the header is dropped
					if (st_byte > `STL_ZERO && st_byte <= `STL_ZERO + 8'h09 && !st_eoi) begin
						ld_ndig  <= st_byte[3:0]; // see RQ26
						ld_count <= 32'h0;
						ld_state <= L_COUNT;
					end else begin
						ld_state <= L_IDLE;
					end
				end
				L_COUNT: begin
					ld_count <= next_count; // see RQ26
					ld_ndig  <= ld_ndig - 4'h1;
					if (st_eoi) begin
						ld_state <= L_IDLE;
					end else if (ld_ndig == 4'h1) begin
						// target fixed here so a later channel change cannot split a table
						ld_state <= L_DATA;
						ld_left  <= next_count;
						ld_pos   <= 3'h0;
						ld_steps <= '0;
						ld_idx   <= cur; // see RQ5
						ld_base  <= tbl_used[cur] ? tbl_base[cur] : ch_base + AW'(cur_free);
						ld_cap   <= tbl_used[cur] ? tbl_size[cur] : need;
						ld_ok    <= tbl_used[cur] | ld_fits;
					end
				end
				L_DATA: begin
					// bytes beyond the count are dropped, never checked; see RQ7
					if (ld_left != 32'h0) begin
						ld_left <= ld_left - 32'h1;
						ld_pos  <= ld_pos + 3'h1;
						ld_entry[8*ld_pos[2:0] +: 8] <= st_byte; // see RQ3
						// counts stored entries only, so the write address stays dense
						if (ld_wr) ld_steps <= ld_steps + SW'(1); // see RQ8
					end
					if (st_eoi) ld_state <= L_IDLE; // see RQ4
				end
				default: ld_state <= L_IDLE;
			endcase
		end
	end

	// single-step define target
	wire logic [AW-1:0] def_base = tbl_used[cur] ? tbl_base[cur] : ch_base + AW'(cur_free);
	wire logic [SW-1:0] def_cap  = tbl_used[cur] ? tbl_size[cur] : DEF_MAX;
	wire logic def_fits = tbl_used[cur] | ((DEP - cur_free) >= DEF_MAX);
	wire logic def_in   = def_fits & (def_step != '0) & (def_step <= def_cap);

	// entry memory writes and synchronous read for the sequencer
	logic [AW-1:0] rd_addr;
	always_ff @(posedge aclk) begin
		if (ld_wr) begin
			// little-endian bytes give loops low, segment, then jump; see RQ25
			mem[ld_base + AW'(ld_steps)] <= {st_byte, ld_entry};
		end else if (def_we && def_in) begin
			mem[def_base + AW'(def_step - SW'(1))] <= {15'h0, wd[0], def_seg, def_loops};
		end
		rd_data <= mem[rd_addr];
	end

	// table allocation, lengths and deletion
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tbl_used <= '0;
			full     <= 1'b0;
			for (int c = 0; c < NCH; c++) free_off[c] <= '0;
		end else if (ld_alloc && !tbl_used[cur]) begin
			// new table takes exactly its steps from the channel region
			if (ld_fits) begin
				tbl_used[cur] <= 1'b1;
				tbl_base[cur] <= ch_base + AW'(cur_free);
				tbl_size[cur] <= need;
				tbl_len[cur]  <= '0;
				free_off[ch]  <= cur_free + need;
			end else begin
				full <= 1'b1;
			end
		end else if (ld_done) begin
			// the closing byte usually completes the last entry in this same cycle
			tbl_len[ld_idx] <= ld_ok ? ld_steps + SW'(ld_wr) : '0; // see RQ8
		end else if (def_we) begin
			// a define into a fresh table reserves the largest step range
			if (!tbl_used[cur] && def_fits) begin
				tbl_used[cur] <= 1'b1;
				tbl_base[cur] <= ch_base + AW'(cur_free);
				tbl_size[cur] <= DEF_MAX;
				free_off[ch]  <= cur_free + DEF_MAX;
			end
			if (!def_fits) full <= 1'b1;
			if (def_in) tbl_len[cur] <= def_step; // see RQ13
		end else if (del_we) begin
			if (wd[`STL_DEL_ALL]) begin
				for (int t = 0; t < NTAB; t++) begin
					tbl_used[TW'(ch * NTAB) + TW'(t)] <= 1'b0; // see RQ17
					tbl_len[TW'(ch * NTAB) + TW'(t)]  <= '0;
				end
				free_off[ch] <= '0;
				full         <= 1'b0;
			end else if (wd[9:0] < 10'(NTAB)) begin
				// slot keeps its region so a shorter table can return; see RQ15
				tbl_len[TW'(ch * NTAB) + TW'(wd[9:0])] <= '0;
			end
		end
	end

	// event pin synchroniser and edge detect
	logic ev_s1;
	logic ev_s2;
	logic ev_last;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_s1   <= 1'b0;
			ev_s2   <= 1'b0;
			ev_last <= 1'b0;
		end else begin
			ev_s1   <= event_in;
			ev_s2   <= ev_s1;
			ev_last <= ev_s2;
		end
	end
	wire logic ev_rise = ev_s2 & ~ev_last;

	// advance source and mode
	wire logic adv = ctrl[`STL_CTRL_JSRC] ? ev_rise : trig_we; // see RQ18 see RQ19
	wire stl_adv_type mode = stl_adv_type'(ctrl[`STL_CTRL_ADV +: 2]);
	wire logic run = ctrl[`STL_CTRL_RUN];

	// step sequencer
	stl_seq_type   sq_state;
	logic [SW-1:0] sq_step;
	logic [31:0]   sq_loops;
	logic          sq_jump;
	logic          run_last;
	wire logic [SW-1:0] sq_len = tbl_len[cur];
	wire logic restart = (run & ~run_last) | (run & def_we) | (run & ld_done); // see RQ14
	wire logic last_step = (sq_step + SW'(1)) >= sq_len;
	assign rd_addr = tbl_base[cur] + AW'(sq_step);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sq_state <= Q_IDLE;
			sq_step  <= '0;
			sq_loops <= 32'h0;
			sq_jump  <= 1'b0;
			seg_out  <= 16'h0000;
			run_last <= 1'b0;
		end else begin
			run_last <= run;
			if (!run || restart) begin
				sq_state <= (run && sq_len != '0) ? Q_FETCH : Q_IDLE;
				sq_step  <= '0;
			end else begin
				unique case (sq_state)
					Q_IDLE: ;
					Q_FETCH: sq_state <= Q_LOAD;
					Q_LOAD: begin
						seg_out  <= rd_data[`STL_SEG_LSB +: 16]; // see RQ10
						sq_loops <= (rd_data[31:0] == 32'h0) ? 32'h1 : rd_data[31:0]; // see RQ11
						sq_jump  <= rd_data[`STL_JMP_LSB];
						sq_state <= Q_PLAY;
					end
					Q_PLAY: if (seg_end) begin
						if (sq_loops > 32'h1) begin
							sq_loops <= sq_loops - 32'h1; // see RQ23
						end else if (mode == STL_STEPPED || sq_jump) begin
							sq_state <= Q_HOLD; // see RQ12 see RQ21 see RQ24
						end else if (last_step && mode == STL_ONCE) begin
							sq_state <= Q_DONE;
						end else begin
							sq_step  <= last_step ? '0 : sq_step + SW'(1); // see RQ20
							sq_state <= Q_FETCH;
						end
					end
					Q_HOLD: if (adv) begin
						if (last_step && mode == STL_ONCE) begin
							sq_state <= Q_DONE;
						end else begin
							sq_step  <= last_step ? '0 : sq_step + SW'(1);
							sq_state <= Q_FETCH;
						end
					end
					Q_DONE: ;
					default: sq_state <= Q_IDLE;
				endcase
			end
		end
	end
	assign seq_active = (sq_state == Q_PLAY) | (sq_state == Q_HOLD);
	assign seq_hold   = (sq_state == Q_HOLD);

	// read channel: one-cycle answer, unmapped reads give zero and slverr
	logic [31:0] rmux;
	logic        rok;
	always_comb begin
		rok = 1'b1;
		unique case (s_axi_araddr)
			`STL_CTRL:      rmux = ctrl; // see RQ22
			`STL_TAB_SEL:   rmux = {22'h0, tab_sel};
			`STL_DEF_STEP:  rmux = 32'(def_step);
			`STL_DEF_SEG:   rmux = {16'h0, def_seg};
			`STL_DEF_LOOPS: rmux = def_loops;
			`STL_STATUS:    rmux = {24'h0, full, sq_state, ld_state, seq_hold, seq_active};
			`STL_STEP:      rmux = 32'(sq_step) + 32'h1;
			`STL_LENGTH:    rmux = 32'(sq_len);
			`STL_SEGMENT:   rmux = {16'h0, seg_out};
			default: begin
				rmux = 32'h0;
				rok  = 1'b0;
			end
		endcase
	end
	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rmux;
			s_axi_rresp  <= rok ? 2'h0 : 2'h2;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : stl_sequence_table_loader
`default_nettype wire

// >>> dv/stl_props.sv
/*
 * checker of the loader's bus handshakes and step outputs.
 * assumes it is bound to the loader top and sees its ports only.
 */
`timescale 1ns/1ps
`default_nettype none

module stl_props #(
	parameter int NCH   = 2,
	parameter int NTAB  = 1000,
	parameter int DEPTH = 32768
) (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// write channels
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// read channels
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// playback side
	input wire logic        event_in,
	input wire logic        seg_end,
	input wire logic [15:0] seg_out,
	input wire logic        seq_active,
	input wire logic        seq_hold
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// a held step with no write and no event pin activity around it
	sequence quiet_s;
		seq_hold && !event_in && !s_axi_awvalid && !s_axi_wvalid && !s_axi_bvalid;
	endsequence
	sequence rd_take_s;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence wr_both_s;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	r_stable_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	r_answer_a: assert property (rd_take_s |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while one pending");
	bad_read_a: assert property (rd_take_s ##0 (s_axi_araddr > 8'h30) |=>
		s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	w_answer_a: assert property (wr_both_s |-> ##[1:3] s_axi_bvalid)
		else $error("write not answered");
	no_accept_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during response");
	hold_keep_a: assert property (quiet_s [*5] |=> seq_hold)
		else $error("step left without advance");
	hold_seg_a: assert property (seq_hold && $past(seq_hold) |-> $stable(seg_out))
		else $error("segment changed while held");
	hold_start_a: assert property ($rose(seq_hold) |-> $past(seg_end))
		else $error("hold entered without a segment end");
endmodule : stl_props

bind stl_sequence_table_loader stl_props #(.NCH(NCH), .NTAB(NTAB), .DEPTH(DEPTH)) props_u (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .event_in(event_in), .seg_end(seg_end),
	.seg_out(seg_out),
	.seq_active(seq_active), .seq_hold(seq_hold));

`default_nettype wire

// >>> dv/stl_playback_model.sv
/*
 * model of the playback engine and the event pin beside the loader.
 * assumes the same clock; the event pin idles low (pulled down).
 */
`timescale 1ns/1ps
`default_nettype none

module stl_playback_model (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// sequencer status
	input  wire logic seq_active,
	input  wire logic seq_hold,
	// bench request for one event pulse
	input  wire logic fire,
	// toward the loader
	output logic      seg_end,
	output logic      event_in
);
	logic [2:0] tick;
	logic [2:0] ev_len;

	// one play lasts eight cycles; a held step never ends on its own
	always_ff @(posedge aclk) begin
		if (!aresetn || !seq_active || seq_hold) begin
			tick    <= 3'h0;
			seg_end <= 1'b0;
		end else begin
			tick    <= tick + 3'h1;
			seg_end <= (tick == 3'h7);
		end
	end

	// pulse wide enough for the pin synchroniser to catch its edge
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ev_len <= 3'h0;
		else if (fire)
			ev_len <= 3'h4;
		else if (ev_len != 3'h0)
			ev_len <= ev_len - 3'h1;
	end
	assign event_in = (ev_len != 3'h0);
endmodule : stl_playback_model

`default_nettype wire

// >>> dv/testbench.sv
/*
 * self-checking bench of the sequence-table loader.
 * assumes the playback model on the far side and a shortened table memory.
 */
`timescale 1ns/1ps
`default_nettype none
`include "stl_defs.svh"

module testbench;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, event_in, seg_end, fire;
	logic        seq_active, seq_hold;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rng;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, wr_resp;
	logic [15:0] seg_out;
	logic [63:0] ent[3];
	logic [33:0] exp_q[$];
	int          fail_count, num_checks, cyc;

	stl_sequence_table_loader #(.NTAB(8), .DEPTH(16384)) dut_u (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .event_in(event_in), .seg_end(seg_end),
		.seg_out(seg_out), .seq_active(seq_active), .seq_hold(seq_hold));

	stl_playback_model play_u (
		.aclk(aclk), .aresetn(aresetn), .seq_active(seq_active),
		.seq_hold(seq_hold), .fire(fire), .seg_end(seg_end), .event_in(event_in));

	// clock
	always #5 aclk = ~aclk;

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs

	task chk(input logic [33:0] got, input logic [33:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	// read answers are compared against the oldest note
	always @(posedge aclk) begin
		if (rvalid && rready && exp_q.size() > 0)
			chk({rresp, rdata}, exp_q.pop_front());
	end

	// cut a hang short
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	// address and data offered together, each released once taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		wr_resp = bresp;
		bready <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge aclk);
		exp_q.push_back({r, e});
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
	endtask : rd

	task sb(input logic [7:0] b, input logic e);
		wr(`STL_STREAM, {23'h0, e, b});
	endtask : sb

	// header with nd count digits for 24 bytes, then three entries
	task dl(input logic [7:0] nd);
		int i;
		sb(8'h23, 1'b0);
		sb(8'h30 + nd, 1'b0);
		if (nd == 8'h3)
			sb(8'h30, 1'b0);
		sb(8'h32, 1'b0);
		sb(8'h34, 1'b0);
		for (i = 0; i < 24; i++)
			sb(ent[i / 8][8 * (i % 8) +: 8], i == 23);
	endtask : dl

	task def(input logic [31:0] st, input logic [31:0] sg, input logic [31:0] jp);
		wr(`STL_DEF_STEP, st);
		wr(`STL_DEF_SEG, sg);
		wr(`STL_DEF_LOOPS, 32'h1);
		wr(`STL_DEF_GO, jp);
	endtask : def

	task wait_for(input logic act, input logic hold);
		int n;
		n = 0;
		while (!(seq_active === act && seq_hold === hold) && n < 3000) begin
			@(posedge aclk);
			n++;
		end
		chk({33'h0, n < 3000}, 34'h1);
	endtask : wait_for

	task cs(input logic [15:0] e);
		chk({18'h0, seg_out}, {18'h0, e});
	endtask : cs

	task pulse_event;
		@(posedge aclk);
		fire <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
	endtask : pulse_event

	// main sequence
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fire} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		rng = 32'h16;
		ent[0] = {16'h0, 16'h0005, 32'h1};
		ent[1] = {16'h1, 16'h0a0d, 32'h2};
		ent[2] = {16'h0, 16'h0d0a, 32'h1};
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`STL_CTRL, 32'h0, 2'b00);
		rd(8'hfc, 32'h0, 2'b10);
		wr(8'hf0, 32'h0);
		chk({32'h0, wr_resp}, 34'h2);
		wr(`STL_DELETE, 32'h8000_0000);
		dl(8'h2);
		rd(`STL_LENGTH, 32'h3, 2'b00);
		// automatic mode runs to the jump step, bus trigger releases it
		wr(`STL_CTRL, 32'h1);
		wait_for(1'b1, 1'b0);
		cs(16'h0005);
		wait_for(1'b1, 1'b1);
		cs(16'h0a0d);
		wr(`STL_TRIGGER, 32'h0);
		wait_for(1'b1, 1'b0);
		cs(16'h0d0a);
		// event source ignores the bus trigger
		wr(`STL_CTRL, 32'h0);
		wr(`STL_CTRL, 32'h9);
		wait_for(1'b1, 1'b1);
		repeat (8) @(posedge aclk);
		wr(`STL_TRIGGER, 32'h0);
		chk({33'h0, seq_hold}, 34'h1);
		pulse_event();
		wait_for(1'b1, 1'b0);
		cs(16'h0d0a);
		// stepped mode holds every step, jump flags or not
		wr(`STL_CTRL, 32'h0);
		wr(`STL_CTRL, 32'h5);
		rd(`STL_CTRL, 32'h5, 2'b00);
		wait_for(1'b1, 1'b1);
		cs(16'h0005);
		wr(`STL_TRIGGER, 32'h0);
		wait_for(1'b1, 1'b0);
		wait_for(1'b1, 1'b1);
		cs(16'h0a0d);
		wr(`STL_TRIGGER, 32'h0);
		wait_for(1'b1, 1'b0);
		wait_for(1'b1, 1'b1);
		cs(16'h0d0a);
		// delete one table, rewrite it no longer, random segments
		wr(`STL_CTRL, 32'h0);
		wr(`STL_DELETE, 32'h0);
		rd(`STL_LENGTH, 32'h0, 2'b00);
		for (int i = 0; i < 3; i++) begin
			rng = xs(rng);
			ent[i][47:32] = rng[15:0] % 16'd16000 + 16'd1;
		end
		dl(8'h3);
		rd(`STL_LENGTH, 32'h3, 2'b00);
		wr(`STL_CTRL, 32'h1);
		wait_for(1'b1, 1'b0);
		cs(ent[0][47:32]);
		wait_for(1'b1, 1'b1);
		cs(ent[1][47:32]);
		// once mode stops after the last step
		wr(`STL_CTRL, 32'h0);
		wr(`STL_CTRL, 32'h3);
		rd(`STL_CTRL, 32'h3, 2'b00);
		wait_for(1'b1, 1'b1);
		wr(`STL_TRIGGER, 32'h0);
		wait_for(1'b1, 1'b0);
		wait_for(1'b0, 1'b0);
		rd(`STL_STEP, 32'h3, 2'b00);
		// single defines, then a redefine while running restarts
		wr(`STL_CTRL, 32'h0);
		wr(`STL_TAB_SEL, 32'h1);
		def(32'h1, 32'd11, 32'h0);
		def(32'h2, 32'd12, 32'h1);
		rd(`STL_LENGTH, 32'h2, 2'b00);
		def(32'h3, 32'd13, 32'h0);
		rd(`STL_LENGTH, 32'h3, 2'b00);
		wr(`STL_CTRL, 32'h1);
		wait_for(1'b1, 1'b1);
		cs(16'd12);
		def(32'h3, 32'd14, 32'h0);
		wait_for(1'b1, 1'b0);
		cs(16'd11);
		// the other channel keeps its own tables
		wr(`STL_CTRL, 32'h100);
		wr(`STL_DELETE, 32'h8000_0000);
		wr(`STL_TAB_SEL, 32'h0);
		rd(`STL_LENGTH, 32'h0, 2'b00);
		wr(`STL_CTRL, 32'h0);
		rd(`STL_LENGTH, 32'h3, 2'b00);
		wr(`STL_DELETE, 32'h8000_0000);
		wr(`STL_TAB_SEL, 32'h1);
		rd(`STL_LENGTH, 32'h0, 2'b00);
		repeat (4) @(posedge aclk);
		tally_and_finish();
	end
endmodule : testbench

`default_nettype wire
